// ---- verilog/i2cssm_engine.sv ----
// i2cssm_engine: status-code driven i2c engine, master transmit/receive
// and slave receive. assumes open-drain pads resolved outside and a
// register master that reads data one cycle after the read strobe.
`timescale 1ns/1ps
module i2cssm_engine
  import i2cssm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // serial interrupt flag level
  output logic serial_irq_flag,
  // bus pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);
  i2cssm_line_if line ();

  i2cssm_state_e state_q, state_d;
  logic [1:0] ph_q, ph_d;
  logic [9:0] tmr_q, tmr_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] dat_q, dat_d;
  logic [7:0] status_q, status_d;
  logic [7:0] adr_q, adr_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic sta_q, sta_d;
  logic sto_q, sto_d;
  logic aa_q, aa_d;
  logic ens_q, ens_d;
  logic master_q, master_d;
  logic rx_q, rx_d;
  logic slave_q, slave_d;
  logic gc_q, gc_d;
  logic first_q, first_d;
  logic lost_q, lost_d;
  logic ackin_q, ackin_d;
  logic txb_q, txb_d;
  logic busy_q, busy_d;
  logic scl_n_q, scl_n_d;
  logic sda_n_q, sda_n_d;
  logic low_q, low_d;
  logic [7:0] code;
  logic [7:0] ctrl_rd;
  logic irq_set;
  logic irq_clr;
  logic sto_clr;
  logic sto_wr;
  logic tdone;

  i2cssm_line_mon u_mon (
    .clk(clk),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .line(line.mon)
  );

  always_comb begin
    state_d = state_q;
    ph_d = ph_q;
    cnt_d = cnt_q;
    dat_d = dat_q;
    adr_d = adr_q;
    sta_d = sta_q;
    aa_d = aa_q;
    ens_d = ens_q;
    master_d = master_q;
    rx_d = rx_q;
    slave_d = slave_q;
    gc_d = gc_q;
    first_d = first_q;
    lost_d = lost_q;
    ackin_d = ackin_q;
    txb_d = txb_q;
    scl_n_d = scl_n_q;
    sda_n_d = sda_n_q;
    low_d = 1'b0;
    code = status_q;
    irq_set = 1'b0;
    irq_clr = 1'b0;
    sto_clr = 1'b0;
    sto_wr = 1'b0;
    tdone = (tmr_q == 10'h000);
    tmr_d = tdone ? tmr_q : tmr_q - 10'h001;
    busy_d = line.start_seen ? 1'b1 : (line.stop_seen ? 1'b0 : busy_q);

    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: begin
          ens_d = reg_wdata[CTRL_ENABLE_BIT];
          sta_d = reg_wdata[CTRL_START_BIT];
          aa_d = reg_wdata[CTRL_ACK_BIT];
          sto_wr = 1'b1;
          // writing one to the flag is ignored; only hardware sets it
          irq_clr = ~reg_wdata[CTRL_IRQ_BIT];
        end
        REG_DATA: dat_d = reg_wdata;
        REG_OWN_ADDR: adr_d = reg_wdata;
        default: ; // status ignores writes
      endcase
    end

    case (state_q)
      S_IDLE: begin
        scl_n_d = 1'b1;
        sda_n_d = 1'b1;
        master_d = 1'b0;
        slave_d = 1'b0;
        if (line.start_seen && aa_q) begin
          // listen for an address; the fall after the start is no bit
          state_d = S_BIT;
          cnt_d = 4'h0;
          ph_d = 2'h3;
          first_d = 1'b1;
          txb_d = 1'b0;
        end else if (sta_q && !busy_q && !irq_q && tdone) begin
          state_d = S_START;
          sda_n_d = 1'b0;
          tmr_d = SCL_HALF_CYC;
          ph_d = 2'h0;
        end
      end
      S_START: begin
        if (tdone && ph_q == 2'h0) begin
          scl_n_d = 1'b0;
          tmr_d = SCL_HALF_CYC;
          ph_d = 2'h1;
        end else if (tdone) begin
          code = SC_START;
          irq_set = 1'b1;
          master_d = 1'b1;
          state_d = S_HOLD;
        end
      end
      S_RSTART: begin
        case (ph_q)
          2'h0: if (tdone) begin
            scl_n_d = 1'b1;
            ph_d = 2'h1;
          end
          2'h1: if (line.scl) begin
            tmr_d = SCL_HALF_CYC;
            ph_d = 2'h2;
          end
          2'h2: if (tdone) begin
            sda_n_d = 1'b0;
            tmr_d = SCL_HALF_CYC;
            ph_d = 2'h3;
          end
          default: if (tdone) begin
            scl_n_d = 1'b0;
            code = SC_RSTART;
            irq_set = 1'b1;
            state_d = S_HOLD;
          end
        endcase
      end
      S_STOP: begin
        case (ph_q)
          2'h0: if (tdone) begin
            scl_n_d = 1'b1;
            ph_d = 2'h1;
          end
          2'h1: if (line.scl) begin
            tmr_d = SCL_HALF_CYC;
            ph_d = 2'h2;
          end
          default: if (tdone) begin
            sda_n_d = 1'b1;
            sto_clr = 1'b1;
            master_d = 1'b0;
            rx_d = 1'b0;
            tmr_d = SCL_HALF_CYC; // bus free time before any new start
            state_d = S_IDLE; // start_request still set retries
          end
        endcase
      end
      S_HOLD: begin
        // scl stays where the byte end left it until software clears the flag
        if (!irq_q) begin
          ph_d = 2'h0;
          cnt_d = 4'h0;
          if (status_q == SC_BUS_ERROR) begin
            // release without a stop and leave the bus
            sto_clr = sto_q;
            scl_n_d = 1'b1;
            sda_n_d = 1'b1;
            state_d = S_IDLE;
          end else if (master_q && sto_q) begin
            sda_n_d = 1'b0;
            tmr_d = SCL_HALF_CYC;
            state_d = S_STOP;
          end else if (master_q && sta_q && status_q != SC_START
                       && status_q != SC_RSTART) begin
            sda_n_d = 1'b1;
            tmr_d = SCL_HALF_CYC;
            state_d = S_RSTART;
          end else if (master_q) begin
            state_d = S_BIT;
            tmr_d = SCL_HALF_CYC;
            first_d = (status_q == SC_START) || (status_q == SC_RSTART);
            if (first_d) begin
              rx_d = dat_q[0];
              txb_d = 1'b1;
              sda_n_d = dat_q[7];
            end else begin
              txb_d = ~rx_q;
              sda_n_d = rx_q ? 1'b1 : dat_q[7];
            end
          end else if (slave_q && status_q != SC_SR_DATA_NACK
                       && status_q != SC_SR_GC_DATA_NACK && status_q != SC_SR_STOP) begin
            state_d = S_BIT;
            txb_d = 1'b0;
            sda_n_d = 1'b1;
            scl_n_d = 1'b1;
          end else begin
            // 38H, 88H, 98H, A0H: not addressed, start_request retries later
            slave_d = 1'b0;
            gc_d = 1'b0;
            scl_n_d = 1'b1;
            sda_n_d = 1'b1;
            state_d = S_IDLE;
          end
        end
      end
      S_BIT: begin
        if (line.start_seen || line.stop_seen) begin
          if (master_q || slave_q) begin
            code = master_q ? SC_BUS_ERROR : SC_SR_STOP;
            irq_set = 1'b1;
            master_d = 1'b0;
            scl_n_d = 1'b1;
            sda_n_d = 1'b1;
            state_d = S_HOLD;
          end else if (line.start_seen) begin
            cnt_d = 4'h0;
            ph_d = 2'h3;
            first_d = 1'b1;
          end else begin
            state_d = S_IDLE;
          end
        end else begin
          if (master_q) begin
            case (ph_q)
              2'h0: if (tdone) begin
                scl_n_d = 1'b1;
                ph_d = 2'h1;
              end
              2'h1: if (line.scl_rise) begin
                tmr_d = SCL_HALF_CYC;
                ph_d = 2'h2;
              end
              default: if (tdone) begin
                scl_n_d = 1'b0;
                tmr_d = SCL_HALF_CYC;
                ph_d = 2'h0;
              end
            endcase
          end
          if (line.scl_rise) begin
            if (cnt_q < 4'h8) begin
              dat_d = {dat_q[6:0], line.sda};
            end else begin
              ackin_d = ~line.sda;
            end
            // released a one but the bus reads zero: someone else won
            if (master_q && txb_q && sda_n_q && !line.sda) begin
              master_d = 1'b0;
              txb_d = 1'b0;
              scl_n_d = 1'b1;
              sda_n_d = 1'b1;
              ph_d = 2'h0;
              if (first_q) begin
                lost_d = 1'b1; // keep listening for our own address
              end else begin
                code = SC_ARB_LOST;
                irq_set = 1'b1;
                state_d = S_HOLD;
              end
            end
          end else if (line.scl_fall && ph_q == 2'h3 && !master_q) begin
            ph_d = 2'h0;
          end else if (line.scl_fall && cnt_q == 4'h7) begin
            cnt_d = 4'h8;
            txb_d = 1'b0;
            sda_n_d = 1'b1;
            if (master_q && rx_q && !first_q) begin
              sda_n_d = ~aa_q;
              txb_d = 1'b1;
            end else if (!master_q && first_q && aa_q) begin
              if (dat_q[7:1] == adr_q[7:1] && !dat_q[0]) begin
                slave_d = 1'b1;
                gc_d = 1'b0;
                sda_n_d = 1'b0;
              end else if (dat_q == GC_ADDRESS && adr_q[ADDR_GC_BIT]) begin
                slave_d = 1'b1;
                gc_d = 1'b1;
                sda_n_d = 1'b0;
              end
            end else if (slave_q && !first_q) begin
              sda_n_d = ~aa_q;
            end
          end else if (line.scl_fall && cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            first_d = 1'b0;
            lost_d = 1'b0;
            sda_n_d = 1'b1;
            state_d = S_HOLD;
            irq_set = 1'b1;
            if (master_q && first_q) begin
              code = rx_q ? (ackin_q ? SC_MR_ADDR_ACK : SC_MR_ADDR_NACK)
                          : (ackin_q ? SC_MT_ADDR_ACK : SC_MT_ADDR_NACK);
            end else if (master_q) begin
              code = rx_q ? (ackin_q ? SC_MR_DATA_ACK : SC_MR_DATA_NACK)
                          : (ackin_q ? SC_MT_DATA_ACK : SC_MT_DATA_NACK);
            end else if (slave_q) begin
              // stretch scl only while the master still expects us
              scl_n_d = ~(first_q | ackin_q);
              if (first_q) begin
                code = gc_q ? (lost_q ? SC_SR_GC_LOST : SC_SR_GC)
                            : (lost_q ? SC_SR_OWN_LOST : SC_SR_OWN);
              end else begin
                code = gc_q ? (ackin_q ? SC_SR_GC_DATA_ACK : SC_SR_GC_DATA_NACK)
                            : (ackin_q ? SC_SR_DATA_ACK : SC_SR_DATA_NACK);
              end
            end else if (lost_q) begin
              code = SC_ARB_LOST;
            end else begin
              irq_set = 1'b0;
              state_d = S_IDLE;
            end
          end else if (line.scl_fall) begin
            cnt_d = cnt_q + 4'h1;
            sda_n_d = txb_q ? dat_q[7] : 1'b1;
          end
        end
      end
      default: state_d = S_IDLE;
    endcase

    if (!ens_q) begin
      state_d = S_IDLE;
      scl_n_d = 1'b1;
      sda_n_d = 1'b1;
      master_d = 1'b0;
      slave_d = 1'b0;
      irq_set = 1'b0;
    end

    // a hardware set in the same cycle as a software clear wins
    irq_d = irq_set | (irq_q & ~irq_clr);
    status_d = irq_set ? {code[7:3], 3'b000} : status_q;
    sto_d = sto_wr ? reg_wdata[CTRL_STOP_BIT] : (sto_q & ~sto_clr);

    ctrl_rd = 8'h00;
    ctrl_rd[CTRL_ENABLE_BIT] = ens_q;
    ctrl_rd[CTRL_START_BIT] = sta_q;
    ctrl_rd[CTRL_STOP_BIT] = sto_q;
    ctrl_rd[CTRL_IRQ_BIT] = irq_q;
    ctrl_rd[CTRL_ACK_BIT] = aa_q;
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: rdata_d = ctrl_rd;
        REG_STATUS: rdata_d = status_q;
        REG_DATA: rdata_d = dat_q;
        default: rdata_d = adr_q;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      ph_q <= 2'h0;
      tmr_q <= 10'h000;
      cnt_q <= 4'h0;
      dat_q <= DATA_RESET;
      status_q <= STATUS_RESET;
      adr_q <= OWN_ADDR_RESET;
      rdata_q <= 8'h00;
      irq_q <= CTRL_RESET[CTRL_IRQ_BIT];
      sta_q <= CTRL_RESET[CTRL_START_BIT];
      sto_q <= CTRL_RESET[CTRL_STOP_BIT];
      aa_q <= CTRL_RESET[CTRL_ACK_BIT];
      ens_q <= CTRL_RESET[CTRL_ENABLE_BIT];
      master_q <= 1'b0;
      rx_q <= 1'b0;
      slave_q <= 1'b0;
      gc_q <= 1'b0;
      first_q <= 1'b0;
      lost_q <= 1'b0;
      ackin_q <= 1'b0;
      txb_q <= 1'b0;
      busy_q <= 1'b0;
      scl_n_q <= 1'b1;
      sda_n_q <= 1'b1;
      low_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ph_q <= ph_d;
      tmr_q <= tmr_d;
      cnt_q <= cnt_d;
      dat_q <= dat_d;
      status_q <= status_d;
      adr_q <= adr_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      sta_q <= sta_d;
      sto_q <= sto_d;
      aa_q <= aa_d;
      ens_q <= ens_d;
      master_q <= master_d;
      rx_q <= rx_d;
      slave_q <= slave_d;
      gc_q <= gc_d;
      first_q <= first_d;
      lost_q <= lost_d;
      ackin_q <= ackin_d;
      txb_q <= txb_d;
      busy_q <= busy_d;
      scl_n_q <= scl_n_d;
      sda_n_q <= sda_n_d;
      low_q <= low_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign serial_irq_flag = irq_q;
  assign scl_oe_n = scl_n_q;
  assign sda_oe_n = sda_n_q;
  assign scl_o = low_q;
  assign sda_o = low_q;
endmodule

// ---- verilog/i2cssm_pkg.sv ----
// i2cssm_pkg: register map, control bit positions, reset values,
// status codes, timing constants and state type for the i2c engine.
// assumes a 100 MHz system clock and a fixed 100 kHz bus rate.
package i2cssm_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_HALF_NS = 5000;
  localparam logic [9:0] SCL_HALF_CYC =
    10'((SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // register offsets
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_OWN_ADDR = 2'h3;

  // serial_control_reg bit positions, and the own address general call bit
  localparam int CTRL_ENABLE_BIT = 6;
  localparam int CTRL_START_BIT = 5;
  localparam int CTRL_STOP_BIT = 4;
  localparam int CTRL_IRQ_BIT = 3;
  localparam int CTRL_ACK_BIT = 2;
  localparam int ADDR_GC_BIT = 0;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'hF8;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] OWN_ADDR_RESET = 8'h00;

  // status codes and the general call address
  localparam logic [7:0] SC_BUS_ERROR = 8'h00;
  localparam logic [7:0] SC_START = 8'h08;
  localparam logic [7:0] SC_RSTART = 8'h10;
  localparam logic [7:0] SC_MT_ADDR_ACK = 8'h18;
  localparam logic [7:0] SC_MT_ADDR_NACK = 8'h20;
  localparam logic [7:0] SC_MT_DATA_ACK = 8'h28;
  localparam logic [7:0] SC_MT_DATA_NACK = 8'h30;
  localparam logic [7:0] SC_ARB_LOST = 8'h38;
  localparam logic [7:0] SC_MR_ADDR_ACK = 8'h40;
  localparam logic [7:0] SC_MR_ADDR_NACK = 8'h48;
  localparam logic [7:0] SC_MR_DATA_ACK = 8'h50;
  localparam logic [7:0] SC_MR_DATA_NACK = 8'h58;
  localparam logic [7:0] SC_SR_OWN = 8'h60;
  localparam logic [7:0] SC_SR_OWN_LOST = 8'h68;
  localparam logic [7:0] SC_SR_GC = 8'h70;
  localparam logic [7:0] SC_SR_GC_LOST = 8'h78;
  localparam logic [7:0] SC_SR_DATA_ACK = 8'h80;
  localparam logic [7:0] SC_SR_DATA_NACK = 8'h88;
  localparam logic [7:0] SC_SR_GC_DATA_ACK = 8'h90;
  localparam logic [7:0] SC_SR_GC_DATA_NACK = 8'h98;
  localparam logic [7:0] SC_SR_STOP = 8'hA0;
  localparam logic [7:0] GC_ADDRESS = 8'h00;

  typedef enum logic [2:0] {S_IDLE, S_START, S_RSTART, S_STOP, S_BIT, S_HOLD} i2cssm_state_e;

endpackage

// ---- verilog/i2cssm_line_if.sv ----
// i2cssm_line_if: synchronised bus levels and events, monitor to engine.
// assumes both ends share one clock.
`timescale 1ns/1ps
interface i2cssm_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  modport mon (output scl, sda, scl_rise, scl_fall, start_seen, stop_seen);
  modport eng (input scl, sda, scl_rise, scl_fall, start_seen, stop_seen);
endinterface

// ---- verilog/i2cssm_line_mon.sv ----
// i2cssm_line_mon: two-flop synchronisers on scl/sda, edge and
// start/stop detection. assumes idle-high open-drain lines.
`timescale 1ns/1ps
module i2cssm_line_mon (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw pins
  input wire logic scl_i,
  input wire logic sda_i,
  // events to the engine
  i2cssm_line_if.mon line
);
  logic [1:0] meta_q, meta_d;
  logic [1:0] sync_q, sync_d;
  logic [1:0] prev_q, prev_d;
  logic [3:0] evt_q, evt_d;

  always_comb begin
    meta_d = {scl_i, sda_i};
    sync_d = meta_q;
    prev_d = sync_q;
    // conditions judged from the second and third stages only, never the first
    evt_d[3] = sync_q[1] & ~prev_q[1];
    evt_d[2] = ~sync_q[1] & prev_q[1];
    evt_d[1] = sync_q[1] & prev_q[1] & prev_q[0] & ~sync_q[0];
    evt_d[0] = sync_q[1] & prev_q[1] & ~prev_q[0] & sync_q[0];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      prev_q <= 2'h3;
      evt_q <= 4'h0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
      evt_q <= evt_d;
    end
  end

  assign line.scl = prev_q[1];
  assign line.sda = prev_q[0];
  assign line.scl_rise = evt_q[3];
  assign line.scl_fall = evt_q[2];
  assign line.start_seen = evt_q[1];
  assign line.stop_seen = evt_q[0];
endmodule

// ---- tb/i2cssm_sva.sv ----
// i2cssm_sva: port-level checks on the i2c engine.
// assumes it is bound to every i2cssm_engine instance.
`timescale 1ns/1ps
module i2cssm_sva
  import i2cssm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic serial_irq_flag,
  // bus pins
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n
);
  logic ctl_w, clr_w;
  logic en_q, en_d, sda_q;
  logic [7:0] own_q, own_d;
  logic [9:0] stc_q, stc_d;
  assign ctl_w = reg_wr && reg_addr == REG_CTRL;
  assign clr_w = ctl_w && !reg_wdata[CTRL_IRQ_BIT];
  always_comb begin
    own_d = (reg_wr && reg_addr == REG_OWN_ADDR) ? reg_wdata : own_q;
    en_d = ctl_w ? reg_wdata[CTRL_ENABLE_BIT] : en_q;
    // stop on the wire: our sda released while scl is high
    stc_d = stc_q;
    if (ctl_w) begin
      stc_d = 10'h000;
    end else if (sda_oe_n && !sda_q && scl_i && scl_oe_n) begin
      stc_d = 10'h001;
    end else if (stc_q != 10'h000 && stc_q != 10'h3FF) begin
      stc_d = stc_q + 10'h001;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      own_q <= OWN_ADDR_RESET;
      en_q <= 1'b0;
      sda_q <= 1'b1;
      stc_q <= 10'h000;
    end else begin
      own_q <= own_d;
      en_q <= en_d;
      sda_q <= sda_oe_n;
      stc_q <= stc_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_status_low: assert property ($past(reg_rd) && $past(reg_addr) == REG_STATUS
    |-> reg_rdata[2:0] == 3'h0) else $error("status low bits set");
  chk_flag_software: assert property ($fell(serial_irq_flag)
    |-> $past(clr_w) || $past(clr_w, 2)) else $error("flag cleared without write");
  chk_hold_pins: assert property (serial_irq_flag && $past(serial_irq_flag)
    |-> $stable(scl_oe_n) && $stable(sda_oe_n)) else $error("bus moved while flag set");
  chk_own_back: assert property ($past(reg_rd) && $past(reg_addr) == REG_OWN_ADDR
    |-> reg_rdata == $past(own_q)) else $error("own address readback wrong");
  chk_stop_cleared: assert property ($past(reg_rd) && $past(reg_addr) == REG_CTRL
    && $past(stc_q) == 10'h3FF |-> !reg_rdata[CTRL_STOP_BIT]) else $error("stop bit kept");
  chk_off_release: assert property (!en_q && !$past(en_q) |-> scl_oe_n && sda_oe_n)
    else $error("drives bus while disabled");
  chk_open_drain: assert property (scl_o == 1'b0 [*2] ##0 sda_o == 1'b0)
    else $error("pin driven high");
  cover property ($rose(serial_irq_flag));
  cover property (stc_q == 10'h3FF);
  cover property ($past(reg_rd) && $past(reg_addr) == REG_OWN_ADDR);
endmodule

bind i2cssm_engine i2cssm_sva chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .serial_irq_flag(serial_irq_flag), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n));

// ---- tb/i2cssm_slave_model.sv ----
// i2cssm_slave_model: write-only slave that acks its own address.
// assumes pulled-up lines; sda released whenever not acking.
`timescale 1ns/1ps
module i2cssm_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // bus
  input wire logic scl,
  input wire logic sda,
  // drive and capture
  output logic sda_oe_n,
  output logic [7:0] last_byte
);
  int n = 0;
  logic sel = 1'b0;
  logic first = 1'b0;
  logic [7:0] sh = 8'h00;
  initial sda_oe_n = 1'b1;
  initial last_byte = 8'h00;
  // start or stop restarts framing
  always @(sda) if (scl === 1'b1) begin
    n = 0;
    first = !sda;
    sel = 1'b0;
  end
  always @(posedge scl) if (n < 8) begin
    sh = {sh[6:0], sda};
    n++;
  end
  always @(negedge scl) begin
    if (n == 8) begin
      if (first) sel = sh[7:1] == ADDR && !sh[0];
      else last_byte = sh;
      first = 1'b0;
      sda_oe_n = !sel; // read address never acked
      n = 9;
    end else if (n == 9) begin
      sda_oe_n = 1'b1;
      n = 0;
    end
  end
endmodule

// ---- tb/i2c_status_state_machine_bench.sv ----
// i2c_status_state_machine_bench: engine as master against one slave,
// then as slave receiver under a master driven by the bench.
// assumes slave address 2A and pull-ups on both lines.
`timescale 1ns/1ps
module i2c_status_state_machine_bench
  import i2cssm_pkg::*;
;
  localparam logic [6:0] SADDR = 7'h2A;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, last_byte;
  logic serial_irq_flag, scl_o, scl_oe_n, sda_o, sda_oe_n, m_oe_n;
  logic bm_scl = 1'b1, bm_sda = 1'b1, ack;
  wire scl = (scl_oe_n | scl_o) & bm_scl;
  wire sda = (sda_oe_n | sda_o) & m_oe_n & bm_sda;
  int fail_count = 0, n_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  i2cssm_engine dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_irq_flag(serial_irq_flag),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n));
  i2cssm_slave_model #(.ADDR(SADDR)) slave_u (.scl(scl), .sda(sda), .sda_oe_n(m_oe_n),
    .last_byte(last_byte));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge clk);
  endtask
  // bounded wait; the flag must come within two bytes' time
  task automatic wait_irq;
    for (int i = 0; i < 20000 && serial_irq_flag !== 1'b1; i++) @(posedge clk);
    chk({7'h00, serial_irq_flag}, 8'h01);
  endtask
  // bench as bus master; 12/13 clock periods average out to 125 ns
  task automatic mstart;
    bm_sda <= 1'b0;
    repeat (6) @(posedge clk);
    bm_scl <= 1'b0;
  endtask
  // sda moves one clock after scl falls, so no false start or stop
  task automatic mbyte(input logic [7:0] b, output logic a);
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      bm_sda <= (i == 8) ? 1'b1 : b[7 - i];
      repeat (5) @(posedge clk);
      bm_scl <= 1'b1;
      @(posedge clk);
      // the engine may stretch scl after its own ack
      while (scl !== 1'b1) @(posedge clk);
      repeat (5 + i % 2) @(posedge clk);
      a = sda;
      bm_scl <= 1'b0;
    end
    @(posedge clk);
  endtask
  task automatic mstop;
    bm_sda <= 1'b0;
    repeat (6) @(posedge clk);
    bm_scl <= 1'b1;
    repeat (6) @(posedge clk);
    bm_sda <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(REG_STATUS, STATUS_RESET);
    wr(REG_STATUS, 8'h55);
    rd(REG_STATUS, STATUS_RESET);
    wr(REG_OWN_ADDR, 8'h31);
    rd(REG_OWN_ADDR, 8'h31);
    $display("test registers done");
    wr(REG_CTRL, 8'h64);
    wait_irq();
    rd(REG_STATUS, SC_START);
    wr(REG_DATA, {SADDR, 1'b0});
    wr(REG_CTRL, 8'h44);
    wait_irq();
    rd(REG_STATUS, SC_MT_ADDR_ACK);
    repeat (2000) @(posedge clk);
    chk({7'h00, scl}, 8'h00);
    wr(REG_DATA, 8'hA5);
    wr(REG_CTRL, 8'h44);
    wait_irq();
    rd(REG_STATUS, SC_MT_DATA_ACK);
    chk(last_byte, 8'hA5);
    $display("test master write done");
    // stop then start, stop bit must be gone by the new start
    wr(REG_CTRL, 8'h74);
    wait_irq();
    rd(REG_STATUS, SC_START);
    rd(REG_CTRL, 8'h6C);
    wr(REG_DATA, {SADDR ^ 7'h01, 1'b0});
    wr(REG_CTRL, 8'h44);
    wait_irq();
    rd(REG_STATUS, SC_MT_ADDR_NACK);
    wr(REG_CTRL, 8'h64);
    wait_irq();
    rd(REG_STATUS, SC_RSTART);
    wr(REG_DATA, {SADDR, 1'b1});
    wr(REG_CTRL, 8'h44);
    wait_irq();
    rd(REG_STATUS, SC_MR_ADDR_NACK);
    wr(REG_CTRL, 8'h54);
    repeat (3000) @(posedge clk);
    rd(REG_CTRL, 8'h44);
    chk({6'h00, scl, sda}, 8'h03);
    $display("test restart and stop done");
    // own address 18 with general call enabled, from the 31 written above
    mstart();
    mbyte(8'h30, ack);
    chk({7'h00, ack}, 8'h00);
    wait_irq();
    rd(REG_STATUS, SC_SR_OWN);
    wr(REG_CTRL, 8'h44);
    mbyte(8'h5A, ack);
    chk({7'h00, ack}, 8'h00);
    wait_irq();
    rd(REG_STATUS, SC_SR_DATA_ACK);
    rd(REG_DATA, 8'h5A);
    wr(REG_CTRL, 8'h40);
    mbyte(8'hC3, ack);
    chk({7'h00, ack}, 8'h01);
    wait_irq();
    rd(REG_STATUS, SC_SR_DATA_NACK);
    wr(REG_CTRL, 8'h44);
    mstop();
    mstart();
    mbyte(GC_ADDRESS, ack);
    chk({7'h00, ack}, 8'h00);
    wait_irq();
    rd(REG_STATUS, SC_SR_GC);
    wr(REG_CTRL, 8'h44);
    mstop();
    wait_irq();
    rd(REG_STATUS, SC_SR_STOP);
    wr(REG_CTRL, 8'h44);
    repeat (20) @(posedge clk);
    chk({6'h00, scl, sda}, 8'h03);
    $display("test slave receive done");
    print_verdict();
  end
endmodule
